/* File: core/mcr_consts.svh */
// Constants for the monitor circular buffer recorder
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define MCR_CLK_MHZ 10
`define MCR_SOM_MIN_NS 3000
`define MCR_SOM_CYC ((`MCR_SOM_MIN_NS * `MCR_CLK_MHZ + 999) / 1000)

// ****************************************
// Address list word indices
// ****************************************
`define MCR_AL_CMD_START 3'h0
`define MCR_AL_CMD_NEXT 3'h1
`define MCR_AL_CMD_END 3'h2
`define MCR_AL_CMD_IRQ 3'h3
`define MCR_AL_DAT_START 3'h4
`define MCR_AL_DAT_NEXT 3'h5
`define MCR_AL_DAT_END 3'h6
`define MCR_AL_DAT_IRQ 3'h7
`define MCR_AL_WORDS 4'h8

// ****************************************
// Entry layout and status word fields
// ****************************************
`define MCR_TT48_SEL 2'h3
`define MCR_CMD_LEN16 4'h4
`define MCR_CMD_LEN48 4'h8
`define MCR_BSW_IDX16 4'h0
`define MCR_BSW_IDX48 4'h3
`define MCR_BSW_DONE_BIT 15
`define MCR_BSW_BEGUN_BIT 14
`define MCR_BSW_BUS_BIT 13
`define MCR_WORD_W 16
`define MCR_FIFO_DEPTH 8
`define MCR_RESET_WORD 16'h0000

`endif

/* File: core/mcr_fifo.sv */
// Word FIFO with registered full and empty
`timescale 1ns/10ps
`default_nettype none
module mcr_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic mclk,
	input wire logic rst,
	mcr_stream_if.snk in_s,
	mcr_stream_if.src out_s
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic full_reg;
	logic empty_reg;
	logic push;
	logic pop;

	assign push = in_s.valid && !full_reg;
	assign pop = out_s.ready && !empty_reg;
	assign in_s.ready = !full_reg;
	assign out_s.valid = !empty_reg;
	assign out_s.data = mem[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_s.data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			full_reg <= 1'b0;
			empty_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			full_reg <= (count_next == (AW + 1)'(D));
			empty_reg <= (count_next == '0);
		end
	end
endmodule : mcr_fifo
`default_nettype wire

/* File: core/mcr_pkg.sv */
// Types shared by the recorder modules
`default_nettype none
package mcr_pkg;
	typedef enum logic [2:0] {
		MCR_IDLE,
		MCR_LOAD,
		MCR_RUN,
		MCR_CMD,
		MCR_WB1,
		MCR_WB5
	} mcr_state_t;
	typedef logic [15:0] mcr_word_t;
endpackage : mcr_pkg
`default_nettype wire

/* File: core/mcr_recorder.sv */
// Monitor recorder: circular command and data buffers in RAM
`include "mcr_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Raise data interrupt when a RAM write hits list word 7, if enabled.
// - List word 6 is the data buffer end, where the pointer rolls over.
// - Host seeds word 5; device writes it back after each message, circularly.
// - List word 4 is the data buffer start boundary.
// - Raise command interrupt when a RAM write hits list word 3, if enabled.
// - List word 2 is the command buffer end, where the pointer rolls over.
// - Host seeds word 1; device writes it back after each message, circularly.
// - List word 0 sits at the list base address input.
// - Command entry is 4 words with 16-bit tags, 8 with 48-bit tags.
// - Data entry holds whatever words the message carried, zero to 35.
// - One status word goes into every command entry.
// - Extended status bits are merged only while extended enable is 1.
// - Bit 15 of the status word is set when the message completes.
// - Completion clears the begun flag, bit 14, in the same update.
// - Begun flag rises 3 us after an accepted command, cleared at end.
// - Unselected messages never start recording or raise the begun flag.
// - Bit 13 is 0 for bus A, 1 for bus B.
// - Select bits equal to 11 choose 48-bit tags and 8-word entries.
module mcr_recorder (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] list_base,
	input wire logic [1:0] time_tag_sel,
	input wire logic ext_status_en,
	input wire logic cmd_irq_en,
	input wire logic data_irq_en,
	input wire logic msg_cmd_done,
	input wire logic msg_selected,
	input wire logic msg_end,
	input wire logic msg_bus_b,
	input wire logic [12:0] msg_status,
	input wire logic [12:0] msg_ext_status,
	input wire logic [15:0] msg_cmd_word,
	input wire logic [47:0] msg_time,
	input wire logic [15:0] msg_gap,
	input wire logic [15:0] msg_len,
	input wire logic word_valid,
	input wire logic [15:0] word_data,
	output logic word_ready,
	output logic [15:0] ram_addr,
	output logic [15:0] ram_wdata,
	output logic ram_we,
	output logic ram_re,
	input wire logic [15:0] ram_rdata,
	output logic message_begun_flag,
	output logic message_done_flag,
	output logic [15:0] record_status_word,
	output logic cmd_irq,
	output logic data_irq
);
	// ****************************************
	// Declarations
	// ****************************************
	mcr_pkg::mcr_state_t state_reg;
	mcr_pkg::mcr_word_t alist_reg [8];
	logic [3:0] ld_idx_reg;
	logic [2:0] re_idx_reg;
	logic cap_vld_reg;
	logic [2:0] cap_idx_reg;
	logic [15:0] cptr_reg;
	logic [15:0] dptr_reg;
	logic [15:0] dblk_reg;
	logic end_pend_reg;
	logic tt48_reg;
	logic [3:0] ent_idx_reg;
	logic [3:0] ent_len;
	logic [3:0] bsw_idx;
	logic [15:0] bsw_reg;
	logic [15:0] cmd_word_reg;
	logic [47:0] time_reg;
	logic [15:0] gap_reg;
	logic [15:0] len_reg;
	logic [15:0] entry_word;
	logic [15:0] ram_addr_reg;
	logic [15:0] ram_wdata_reg;
	logic ram_we_reg;
	logic ram_re_reg;
	logic wr_bsw_reg;
	logic [5:0] som_cnt_reg;
	logic som_run_reg;
	logic begun_reg;
	logic done_reg;
	logic [15:0] status_out_reg;
	logic cmd_irq_reg;
	logic data_irq_reg;
	logic accept;
	logic active;
	logic pop;
	logic [5:0] since_acc_reg;

	mcr_stream_if #(.W(`MCR_WORD_W)) in_s ();
	mcr_stream_if #(.W(`MCR_WORD_W)) out_s ();

	// Steps a circular pointer, rolling over at the end boundary
	function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic [15:0] lo, input logic [15:0] hi);
		step_ptr = (p == hi) ? lo : p + 16'h0001;
	endfunction : step_ptr

	assign accept = (state_reg == mcr_pkg::MCR_IDLE) && msg_cmd_done && msg_selected;
	assign active = (state_reg == mcr_pkg::MCR_LOAD) || (state_reg == mcr_pkg::MCR_RUN);
	assign pop = (state_reg == mcr_pkg::MCR_RUN) && out_s.valid;
	assign ent_len = tt48_reg ? `MCR_CMD_LEN48 : `MCR_CMD_LEN16;
	assign bsw_idx = tt48_reg ? `MCR_BSW_IDX48 : `MCR_BSW_IDX16;

	// ****************************************
	// Data word buffer
	// ****************************************
	assign in_s.valid = word_valid;
	assign in_s.data = word_data;
	assign out_s.ready = (state_reg == mcr_pkg::MCR_RUN);

	mcr_fifo #(.W(`MCR_WORD_W), .D(`MCR_FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_s(in_s),
		.out_s(out_s)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= mcr_pkg::MCR_IDLE;
		end else begin
			unique case (state_reg)
				mcr_pkg::MCR_IDLE: begin
					if (accept) begin
						state_reg <= mcr_pkg::MCR_LOAD;
					end
				end
				mcr_pkg::MCR_LOAD: begin
					if (cap_vld_reg && cap_idx_reg == `MCR_AL_DAT_IRQ) begin
						state_reg <= mcr_pkg::MCR_RUN;
					end
				end
				mcr_pkg::MCR_RUN: begin
					if (end_pend_reg && !out_s.valid) begin
						state_reg <= mcr_pkg::MCR_CMD;
					end
				end
				mcr_pkg::MCR_CMD: begin
					if (ent_idx_reg == ent_len - 4'h1) begin
						state_reg <= mcr_pkg::MCR_WB1;
					end
				end
				mcr_pkg::MCR_WB1: begin
					state_reg <= mcr_pkg::MCR_WB5;
				end
				mcr_pkg::MCR_WB5: begin
					state_reg <= mcr_pkg::MCR_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Address list load
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			ld_idx_reg <= 4'h0;
			re_idx_reg <= 3'h0;
			cap_vld_reg <= 1'b0;
			cap_idx_reg <= 3'h0;
			for (int i = 0; i < 8; i++) begin
				alist_reg[i] <= `MCR_RESET_WORD;
			end
		end else begin
			if (accept) begin
				ld_idx_reg <= 4'h0;
			end else if (state_reg == mcr_pkg::MCR_LOAD && ld_idx_reg != `MCR_AL_WORDS) begin
				ld_idx_reg <= ld_idx_reg + 4'h1;
			end
			re_idx_reg <= ld_idx_reg[2:0];
			cap_vld_reg <= ram_re_reg;
			cap_idx_reg <= re_idx_reg;
			if (cap_vld_reg) begin
				alist_reg[cap_idx_reg] <= ram_rdata;
			end
		end
	end

	// ****************************************
	// Message capture
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			end_pend_reg <= 1'b0;
			tt48_reg <= 1'b0;
			bsw_reg <= `MCR_RESET_WORD;
			cmd_word_reg <= `MCR_RESET_WORD;
			time_reg <= 48'h0;
			gap_reg <= `MCR_RESET_WORD;
			len_reg <= `MCR_RESET_WORD;
		end else begin
			if (accept) begin
				end_pend_reg <= 1'b0;
				tt48_reg <= (time_tag_sel == `MCR_TT48_SEL);
			end else if (active && msg_end && !end_pend_reg) begin
				end_pend_reg <= 1'b1;
				bsw_reg <= {1'b1, 1'b0, msg_bus_b, msg_status | (ext_status_en ? msg_ext_status : 13'h0)};
				cmd_word_reg <= msg_cmd_word;
				time_reg <= msg_time;
				gap_reg <= msg_gap;
				len_reg <= msg_len;
			end
		end
	end

	// ****************************************
	// Command entry layout
	// ****************************************
	always_comb begin
		entry_word = bsw_reg;
		if (tt48_reg) begin
			unique case (ent_idx_reg[2:0])
				3'h0: entry_word = time_reg[15:0];
				3'h1: entry_word = time_reg[31:16];
				3'h2: entry_word = time_reg[47:32];
				3'h3: entry_word = bsw_reg;
				3'h4: entry_word = gap_reg;
				3'h5: entry_word = len_reg;
				3'h6: entry_word = dblk_reg;
				3'h7: entry_word = cmd_word_reg;
			endcase
		end else begin
			unique case (ent_idx_reg[1:0])
				2'h0: entry_word = bsw_reg;
				2'h1: entry_word = time_reg[15:0];
				2'h2: entry_word = dblk_reg;
				2'h3: entry_word = cmd_word_reg;
			endcase
		end
	end

	// ****************************************
	// Buffer pointers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			cptr_reg <= `MCR_RESET_WORD;
			dptr_reg <= `MCR_RESET_WORD;
			dblk_reg <= `MCR_RESET_WORD;
			ent_idx_reg <= 4'h0;
		end else begin
			if (cap_vld_reg && cap_idx_reg == `MCR_AL_CMD_NEXT) begin
				cptr_reg <= ram_rdata;
			end else if (state_reg == mcr_pkg::MCR_CMD) begin
				cptr_reg <= step_ptr(cptr_reg, alist_reg[`MCR_AL_CMD_START], alist_reg[`MCR_AL_CMD_END]);
			end
			if (cap_vld_reg && cap_idx_reg == `MCR_AL_DAT_NEXT) begin
				dptr_reg <= ram_rdata;
				dblk_reg <= ram_rdata;
			end else if (pop) begin
				dptr_reg <= step_ptr(dptr_reg, alist_reg[`MCR_AL_DAT_START], alist_reg[`MCR_AL_DAT_END]);
			end
			if (state_reg == mcr_pkg::MCR_CMD) begin
				ent_idx_reg <= ent_idx_reg + 4'h1;
			end else begin
				ent_idx_reg <= 4'h0;
			end
		end
	end

	// ****************************************
	// RAM port
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			ram_addr_reg <= `MCR_RESET_WORD;
			ram_wdata_reg <= `MCR_RESET_WORD;
			ram_we_reg <= 1'b0;
			ram_re_reg <= 1'b0;
			wr_bsw_reg <= 1'b0;
		end else begin
			ram_we_reg <= 1'b0;
			ram_re_reg <= 1'b0;
			wr_bsw_reg <= 1'b0;
			if (state_reg == mcr_pkg::MCR_LOAD && ld_idx_reg != `MCR_AL_WORDS) begin
				ram_re_reg <= 1'b1;
				ram_addr_reg <= list_base + {12'h000, ld_idx_reg};
			end else if (pop) begin
				ram_we_reg <= 1'b1;
				ram_addr_reg <= dptr_reg;
				ram_wdata_reg <= out_s.data;
			end else if (state_reg == mcr_pkg::MCR_CMD) begin
				ram_we_reg <= 1'b1;
				ram_addr_reg <= cptr_reg;
				ram_wdata_reg <= entry_word;
				wr_bsw_reg <= (ent_idx_reg == bsw_idx);
			end else if (state_reg == mcr_pkg::MCR_WB1) begin
				ram_we_reg <= 1'b1;
				ram_addr_reg <= list_base + {13'h0, `MCR_AL_CMD_NEXT};
				ram_wdata_reg <= cptr_reg;
			end else if (state_reg == mcr_pkg::MCR_WB5) begin
				ram_we_reg <= 1'b1;
				ram_addr_reg <= list_base + {13'h0, `MCR_AL_DAT_NEXT};
				ram_wdata_reg <= dptr_reg;
			end
		end
	end

	// ****************************************
	// Message flags
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			som_cnt_reg <= 6'h00;
			som_run_reg <= 1'b0;
			begun_reg <= 1'b0;
			done_reg <= 1'b0;
			status_out_reg <= `MCR_RESET_WORD;
		end else begin
			if (accept) begin
				som_cnt_reg <= 6'h00;
				som_run_reg <= 1'b1;
				done_reg <= 1'b0;
			end else if (active && msg_end) begin
				som_run_reg <= 1'b0;
			end else if (som_run_reg) begin
				som_cnt_reg <= som_cnt_reg + 6'h01;
				if (som_cnt_reg == 6'(`MCR_SOM_CYC - 1)) begin
					som_run_reg <= 1'b0;
					begun_reg <= 1'b1;
				end
			end
			if (state_reg == mcr_pkg::MCR_RUN && end_pend_reg && !out_s.valid) begin
				done_reg <= 1'b1;
				begun_reg <= 1'b0;
				status_out_reg <= bsw_reg;
			end
		end
	end

	// ****************************************
	// Utilization interrupts
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			cmd_irq_reg <= 1'b0;
			data_irq_reg <= 1'b0;
		end else begin
			cmd_irq_reg <= cmd_irq_en && ram_we_reg && (ram_addr_reg == alist_reg[`MCR_AL_CMD_IRQ]);
			data_irq_reg <= data_irq_en && ram_we_reg && (ram_addr_reg == alist_reg[`MCR_AL_DAT_IRQ]);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || accept) begin
			since_acc_reg <= 6'h00;
		end else if (since_acc_reg != 6'h3f) begin
			since_acc_reg <= since_acc_reg + 6'h01;
		end
	end

	assign word_ready = in_s.ready;
	assign ram_addr = ram_addr_reg;
	assign ram_wdata = ram_wdata_reg;
	assign ram_we = ram_we_reg;
	assign ram_re = ram_re_reg;
	assign message_begun_flag = begun_reg;
	assign message_done_flag = done_reg;
	assign record_status_word = status_out_reg;
	assign cmd_irq = cmd_irq_reg;
	assign data_irq = data_irq_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence cmd_last_s;
		state_reg == mcr_pkg::MCR_CMD ##1 state_reg == mcr_pkg::MCR_WB1;
	endsequence

	sequence list_wb_s;
		ram_we_reg && ram_addr_reg == list_base + 16'h0001 ##1
		ram_we_reg && ram_addr_reg == list_base + 16'h0005;
	endsequence

	som_delay_a: assert property ($rose(begun_reg) |-> since_acc_reg == 6'(`MCR_SOM_CYC))
		else $error("begun flag rose at the wrong time");
	eom_clear_a: assert property ($rose(done_reg) |-> !begun_reg && status_out_reg[15:14] == 2'h2)
		else $error("done and begun flags disagree");
	bsw_bits_a: assert property (wr_bsw_reg |-> ram_wdata_reg[15] && !ram_wdata_reg[14]
		&& ram_wdata_reg[13] == bsw_reg[13])
		else $error("status word top bits wrong");
	ext_gate_a: assert property (active && msg_end && !end_pend_reg && !accept && !ext_status_en
		|=> bsw_reg[12:0] == $past(msg_status))
		else $error("extended status leaked");
	entry_len_a: assert property (cmd_last_s |-> $past(ent_idx_reg) == ent_len - 4'h1 ##1 list_wb_s)
		else $error("command entry length or write-back wrong");
	data_wrap_a: assert property (pop && dptr_reg == alist_reg[`MCR_AL_DAT_END] |=> dptr_reg == alist_reg[`MCR_AL_DAT_START])
		else $error("data pointer did not wrap");
	cmd_wrap_a: assert property (state_reg == mcr_pkg::MCR_CMD && cptr_reg == alist_reg[`MCR_AL_CMD_END]
		|=> cptr_reg == alist_reg[`MCR_AL_CMD_START])
		else $error("command pointer did not wrap");
	cmd_irq_a: assert property (ram_we_reg && cmd_irq_en && ram_addr_reg == alist_reg[`MCR_AL_CMD_IRQ] |=> cmd_irq_reg)
		else $error("command interrupt missed");
	data_irq_a: assert property (data_irq_reg |-> $past(ram_we_reg) && $past(data_irq_en))
		else $error("spurious data interrupt");
	filter_a: assert property (state_reg == mcr_pkg::MCR_IDLE && msg_cmd_done && !msg_selected
		|=> state_reg == mcr_pkg::MCR_IDLE && !$rose(begun_reg))
		else $error("filtered message recorded");
	list_base_a: assert property ($rose(ram_re_reg) |-> ram_addr_reg == list_base)
		else $error("list read not at base");
endmodule : mcr_recorder
`default_nettype wire

/* File: core/mcr_stream_if.sv */
// Valid/ready word stream between recorder modules
`timescale 1ns/10ps
`default_nettype none
interface mcr_stream_if #(parameter int W = 16);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : mcr_stream_if
`default_nettype wire

/* File: verif/mcr_ram_model.sv */
// RAM model standing behind the recorder's memory port
`timescale 1ns/10ps
`default_nettype none
module mcr_ram_model (
	input wire logic mclk,
	input wire logic [15:0] ram_addr,
	input wire logic [15:0] ram_wdata,
	input wire logic ram_we,
	input wire logic ram_re,
	output logic [15:0] ram_rdata
);
	logic [15:0] mem [0:1023];
	// ****************************************
	// Write and delayed read
	// ****************************************
	always @(posedge mclk) begin
		if (ram_we) begin
			mem[ram_addr[9:0]] <= ram_wdata;
		end
		// Idle bus shows the inverse of the addressed word, never a valid read
		if (ram_re) begin
			ram_rdata <= mem[ram_addr[9:0]];
		end else begin
			ram_rdata <= ~mem[ram_addr[9:0]];
		end
	end
endmodule : mcr_ram_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the monitor recorder
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct {logic [15:0] a; logic [15:0] d;} mcr_wr_t;
	localparam logic [15:0] base = 16'h0040, cst = 16'h0100, cend = 16'h010b, cirq = 16'h0108;
	localparam logic [15:0] dst = 16'h0200, dend = 16'h0226, dirq = 16'h0210;
	logic mclk = 1'b0, rst, ext_status_en, cmd_irq_en, data_irq_en, msg_cmd_done, msg_selected, msg_end;
	logic msg_bus_b, word_valid, word_ready, ram_we, ram_re, message_begun_flag, message_done_flag;
	logic cmd_irq, data_irq, ecirq, edirq;
	logic [1:0] time_tag_sel;
	logic [12:0] msg_status, msg_ext_status;
	logic [15:0] msg_cmd_word, msg_gap, msg_len, word_data, ram_addr, ram_wdata, ram_rdata;
	logic [15:0] record_status_word, cptr, dptr;
	logic [47:0] msg_time;
	mcr_wr_t wq [$];
	mcr_wr_t e;
	int err_total, n_compared, cyc;
	int n_tab [5] = '{0, 35, 9, 20, 8};
	logic [1:0] tt_tab [5] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h3};
	mcr_recorder mcr_recorder_i (.mclk(mclk), .rst(rst), .list_base(base), .time_tag_sel(time_tag_sel),
		.ext_status_en(ext_status_en), .cmd_irq_en(cmd_irq_en), .data_irq_en(data_irq_en),
		.msg_cmd_done(msg_cmd_done), .msg_selected(msg_selected), .msg_end(msg_end), .msg_bus_b(msg_bus_b),
		.msg_status(msg_status), .msg_ext_status(msg_ext_status), .msg_cmd_word(msg_cmd_word),
		.msg_time(msg_time), .msg_gap(msg_gap), .msg_len(msg_len), .word_valid(word_valid),
		.word_data(word_data), .word_ready(word_ready), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata), .message_begun_flag(message_begun_flag),
		.message_done_flag(message_done_flag), .record_status_word(record_status_word),
		.cmd_irq(cmd_irq), .data_irq(data_irq));
	mcr_ram_model mcr_ram_model_i (.mclk(mclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
		.ram_re(ram_re), .ram_rdata(ram_rdata));
	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic expect_wr(input logic [15:0] a, input logic [15:0] d);
		wq.push_back('{a, d});
	endtask : expect_wr
	function automatic logic [15:0] stp(input logic [15:0] p, input logic [15:0] s, input logic [15:0] en);
		return (p == en) ? s : p + 16'h0001;
	endfunction : stp
	// ****************************************
	// Clock, timeout and write monitor
	// ****************************************
	initial begin
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end
	always @(negedge mclk) begin
		check("cmd irq", {15'h0000, cmd_irq}, {15'h0000, ecirq});
		check("data irq", {15'h0000, data_irq}, {15'h0000, edirq});
		ecirq = 1'b0;
		edirq = 1'b0;
		if (ram_re === 1'b1) check("list read", {15'h0000, (ram_addr - base) < 16'h0008}, 16'h0001);
		if (ram_we === 1'b1) begin
			if (wq.size() == 0) begin
				check("queued writes", 16'h0000, 16'h0001);
			end else begin
				e = wq.pop_front();
				check("write addr", ram_addr, e.a);
				check("write data", ram_wdata, e.d);
				ecirq = cmd_irq_en && (e.a == cirq);
				edirq = data_irq_en && (e.a == dirq);
			end
		end
	end
	// ****************************************
	// Stimulus
	// ****************************************
	task automatic push(input logic [15:0] d);
		int t;
		t = 0;
		word_valid <= 1'b1;
		word_data <= d;
		@(negedge mclk);
		while (word_ready !== 1'b1 && t < 100) begin
			@(negedge mclk);
			t++;
		end
		@(posedge mclk);
	endtask : push
	task automatic send_msg(input int i);
		logic [15:0] db, sw, cw, gp, ln;
		logic [12:0] st, xs;
		logic [47:0] tm;
		logic [15:0] ent [$];
		logic [15:0] dat [$];
		logic xe;
		int k0, t;
		st = 13'($urandom());
		xs = 13'($urandom());
		tm = 48'({$urandom(), $urandom()});
		cw = 16'($urandom());
		gp = 16'($urandom());
		ln = 16'($urandom());
		xe = (i % 3) != 0;
		db = dptr;
		for (int k = 0; k < n_tab[i]; k++) begin
			dat.push_back(16'($urandom()));
			expect_wr(dptr, dat[k]);
			dptr = stp(dptr, dst, dend);
		end
		sw = {1'b1, 1'b0, i[0], st | (xe ? xs : 13'h0000)};
		if (tt_tab[i] == 2'h3) ent = {tm[15:0], tm[31:16], tm[47:32], sw, gp, ln, db, cw};
		else ent = {sw, tm[15:0], db, cw};
		foreach (ent[k]) begin
			expect_wr(cptr, ent[k]);
			cptr = stp(cptr, cst, cend);
		end
		expect_wr(base + 16'h0001, cptr);
		expect_wr(base + 16'h0005, dptr);
		@(posedge mclk);
		time_tag_sel <= tt_tab[i];
		ext_status_en <= xe;
		msg_bus_b <= i[0];
		msg_status <= st;
		msg_ext_status <= xs;
		msg_cmd_word <= cw;
		msg_time <= tm;
		msg_gap <= gp;
		msg_len <= ln;
		cmd_irq_en <= (i != 2);
		data_irq_en <= (i != 3);
		msg_selected <= 1'b1;
		msg_cmd_done <= 1'b1;
		@(posedge mclk);
		msg_cmd_done <= 1'b0;
		k0 = cyc;
		for (int k = 0; k < n_tab[i] && k < 8; k++) push(dat[k]);
		word_valid <= 1'b0;
		if (n_tab[i] >= 8) begin
			@(negedge mclk);
			check("fifo full", {15'h0000, word_ready}, 16'h0000);
		end
		do @(negedge mclk); while (cyc < k0 + 30);
		check("begun early", {15'h0000, message_begun_flag}, 16'h0000);
		@(negedge mclk);
		check("begun set", {15'h0000, message_begun_flag}, 16'h0001);
		// A second command while busy must be ignored
		@(posedge mclk);
		msg_cmd_done <= 1'b1;
		@(posedge mclk);
		msg_cmd_done <= 1'b0;
		for (int k = 8; k < n_tab[i]; k++) push(dat[k]);
		word_valid <= 1'b0;
		msg_end <= 1'b1;
		@(posedge mclk);
		msg_end <= 1'b0;
		t = 0;
		do begin
			@(negedge mclk);
			t++;
		end while (message_done_flag !== 1'b1 && t < 300);
		check("done flag", {15'h0000, message_done_flag}, 16'h0001);
		check("begun cleared", {15'h0000, message_begun_flag}, 16'h0000);
		check("status word", record_status_word, sw);
		t = 0;
		while (wq.size() != 0 && t < 100) begin
			@(negedge mclk);
			t++;
		end
		check("writes left", 16'(wq.size()), 16'h0000);
		@(posedge mclk);
	endtask : send_msg
	initial begin
		{rst, ext_status_en, cmd_irq_en, data_irq_en, msg_cmd_done, msg_selected, msg_end} = 7'h40;
		{msg_bus_b, word_valid, time_tag_sel, msg_status, msg_ext_status} = 30'h00000000;
		{msg_cmd_word, msg_gap, msg_len, word_data, msg_time} = 112'h0;
		{err_total, n_compared, cyc, ecirq, edirq} = '0;
		cptr = cst;
		dptr = dst;
		void'($urandom(52282));
		mcr_ram_model_i.mem[base[9:0]] = cst;
		mcr_ram_model_i.mem[base[9:0] + 10'h001] = cst;
		mcr_ram_model_i.mem[base[9:0] + 10'h002] = cend;
		mcr_ram_model_i.mem[base[9:0] + 10'h003] = cirq;
		mcr_ram_model_i.mem[base[9:0] + 10'h004] = dst;
		mcr_ram_model_i.mem[base[9:0] + 10'h005] = dst;
		mcr_ram_model_i.mem[base[9:0] + 10'h006] = dend;
		mcr_ram_model_i.mem[base[9:0] + 10'h007] = dirq;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// Filtered command and a stray end must leave the block idle
		msg_cmd_done <= 1'b1;
		@(posedge mclk);
		msg_cmd_done <= 1'b0;
		msg_end <= 1'b1;
		@(posedge mclk);
		msg_end <= 1'b0;
		repeat (40) begin
			@(negedge mclk);
			check("idle", {14'h0000, ram_re, message_begun_flag}, 16'h0000);
		end
		for (int i = 0; i < 5; i++) send_msg(i);
		test_done();
	end
endmodule : testbench
`default_nettype wire
